// ---- logic/square_wave_gen.sv ----
// Square-wave flag divider: one output toggling every half period
`timescale 1ns/100ps
module square_wave_gen #(
  parameter int unsigned HALF_CYCLES = 200_000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ms_tick,
  input  wire logic restart,
  output logic      wave_q
);

  localparam int unsigned CW = $clog2(HALF_CYCLES + 1);
  logic [CW-1:0] count_q;

  // Counts ms ticks; reload gives exactly half the period between inversions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      wave_q  <= 1'b0;
    end else if (restart) begin
      count_q <= '0;
      wave_q  <= 1'b0;
    end else if (ms_tick) begin
      if (count_q == CW'(HALF_CYCLES - 1)) begin
        count_q <= '0;
        wave_q  <= ~wave_q;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  a_wave_held_restart : assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> !wave_q) else $error("square wave not low after restart");

endmodule : square_wave_gen

// ---- logic/sysflag_gen.sv ----
// System flag generator: fault, scan, square-wave and calendar flags over APB
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
// Operation
// - Block fault latch stays set from an operation error until the block ends.
// - Software may clear the block fault latch by writing it.
// - Operation fault flag follows the result of the latest function or block.
// - Eight square waves, 20 ms to 60 s, each inverting every half period.
// - Square waves restart low when initialization or scan program begins.
// - Constant-high flag always reads set.
// - Constant-low flag always reads cleared.
// - First-scan-high is set during the first scan only.
// - First-scan-low is cleared during the first scan only.
// - Scan parity inverts each scan and is set in the first scan.
// - Init routine sets startup-complete; scans start only after init ends.
// - Date is a day count with 1 January 1984 as day zero.
// - Time of day counts milliseconds since midnight.
// - Native weekday: 0 Sunday up to 6 Saturday.
// - Legacy weekday: 0 Monday up to 6 Sunday.
module sysflag_gen (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire sysflag_pkg::run_event_s run_event,
  input  wire logic                   init_done,
  output logic                        scan_enable_q,
  output logic      [7:0]             flags_q,
  output logic      [7:0]             square_wave_q,
  output logic                        irq_q
);

  localparam int unsigned NW = sysflag_pkg::SQW_COUNT;

  sysflag_pkg::phase_e phase_q;
  logic                block_fault_latch_q;
  logic                op_fault_q;
  logic                first_scan_q;
  logic                scan_parity_q;
  logic                init_flag_q;
  logic                legacy_q;
  logic [31:0]         date_q;
  logic [31:0]         tod_q;
  logic [2:0]          week_q;
  logic [14:0]         ms_div_q;
  logic                ms_tick;
  logic                wave_restart;
  logic [NW-1:0]       waves;
  logic [sysflag_pkg::IRQ_WIDTH-1:0] irq_stat_q;
  logic [sysflag_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic                wr_en;
  logic                rd_en;
  logic                set_clk;
  logic [31:0]         rd_d;
  logic                latch_clr;
  logic [2:0]          week_out;

  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && !penable && !pwrite;
  assign latch_clr = wr_en && paddr == sysflag_pkg::OFS_FLAGS && pwdata[sysflag_pkg::FLG_LATCH];
  assign set_clk   = wr_en && paddr == sysflag_pkg::OFS_CTRL && pwdata[sysflag_pkg::CTL_SETCLK];

  // Run phase: init runs until its routine ends, then scans are allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= sysflag_pkg::PH_IDLE;
    end else begin
      unique case (phase_q)
        sysflag_pkg::PH_IDLE: begin
          if (run_event.program_start) begin
            phase_q <= sysflag_pkg::PH_INIT;
          end
        end
        sysflag_pkg::PH_INIT: begin
          if (init_flag_q && run_event.block_end) begin
            phase_q <= sysflag_pkg::PH_WAIT;
          end
        end
        sysflag_pkg::PH_WAIT: begin
          if (run_event.scan_start) begin
            phase_q <= sysflag_pkg::PH_SCAN;
          end
        end
        sysflag_pkg::PH_SCAN: begin
          if (run_event.program_start) begin
            phase_q <= sysflag_pkg::PH_INIT;
          end
        end
        default: phase_q <= sysflag_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_enable_q <= 1'b0;
    end else begin
      scan_enable_q <= (phase_q == sysflag_pkg::PH_WAIT) || (phase_q == sysflag_pkg::PH_SCAN);
    end
  end

  // Startup-complete flag written by the init routine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_flag_q <= 1'b0;
    end else if (run_event.program_start) begin
      init_flag_q <= 1'b0;
    end else if (init_done) begin
      init_flag_q <= 1'b1;
    end
  end

  // Fault latch: set wins over a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_fault_latch_q <= 1'b0;
    end else if (run_event.op_done && run_event.op_fault) begin
      block_fault_latch_q <= 1'b1;
    end else if (run_event.block_end || latch_clr) begin
      block_fault_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_fault_q <= 1'b0;
    end else if (run_event.op_done) begin
      op_fault_q <= run_event.op_fault;
    end
  end

  // First scan and parity, reset at each program start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_scan_q  <= 1'b0;
      scan_parity_q <= 1'b0;
    end else if (run_event.program_start) begin
      first_scan_q  <= 1'b0;
      scan_parity_q <= 1'b0;
    end else if (run_event.scan_start && scan_enable_q) begin
      first_scan_q  <= (phase_q == sysflag_pkg::PH_WAIT);
      scan_parity_q <= (phase_q == sysflag_pkg::PH_WAIT) ? 1'b1 : ~scan_parity_q;
    end
  end

  // Millisecond enable pulse from the system clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_q <= '0;
    end else if (ms_div_q == 15'(sysflag_pkg::MS_CYCLES - 1)) begin
      ms_div_q <= '0;
    end else begin
      ms_div_q <= ms_div_q + 1'b1;
    end
  end
  assign ms_tick = (ms_div_q == 15'(sysflag_pkg::MS_CYCLES - 1));

  assign wave_restart = run_event.program_start ||
                        (run_event.scan_start && phase_q == sysflag_pkg::PH_WAIT);

  generate
    for (genvar i = 0; i < NW; i++) begin : g_wave
      square_wave_gen #(
        .HALF_CYCLES(sysflag_pkg::SQW_PERIOD_MS[i] / 2)
      ) u_wave (
        .pclk   (pclk),
        .presetn(presetn),
        .ms_tick(ms_tick),
        .restart(wave_restart),
        .wave_q (waves[i])
      );
    end
  endgenerate

  // Real-time clock; a software write sets date and time-of-day
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      date_q <= '0;
      tod_q  <= '0;
      week_q <= sysflag_pkg::DAY0_WEEKDAY;
    end else if (wr_en && paddr == sysflag_pkg::OFS_DATE) begin
      date_q <= pwdata;
      week_q <= 3'((pwdata % sysflag_pkg::DAYS_PER_WEEK) + sysflag_pkg::DAY0_WEEKDAY);
    end else if (wr_en && paddr == sysflag_pkg::OFS_TOD) begin
      tod_q <= pwdata;
    end else if (ms_tick) begin
      if (tod_q == 32'(sysflag_pkg::MS_PER_DAY - 1)) begin
        tod_q  <= '0;
        date_q <= date_q + 1'b1;
        week_q <= (week_q == 3'h6) ? 3'h0 : week_q + 1'b1;
      end else begin
        tod_q <= tod_q + 1'b1;
      end
    end
  end

  // Legacy numbering shifts Monday to zero
  assign week_out = legacy_q ? ((week_q == 3'h0) ? 3'h6 : week_q - 1'b1) : week_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legacy_q <= 1'b0;
    end else if (wr_en && paddr == sysflag_pkg::OFS_CTRL) begin
      legacy_q <= pwdata[sysflag_pkg::CTL_LEGACY];
    end
  end

  // Interrupts: fault and scan start; write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == sysflag_pkg::OFS_IRQ_STAT) ?
                     pwdata[sysflag_pkg::IRQ_WIDTH-1:0] : '0)) |
                    {run_event.scan_start && scan_enable_q, run_event.op_done && run_event.op_fault};
      if (wr_en && paddr == sysflag_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[sysflag_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Registered flag outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q       <= 8'h00;
      square_wave_q <= 8'h00;
    end else begin
      flags_q[sysflag_pkg::FLG_LATCH]  <= block_fault_latch_q;
      flags_q[sysflag_pkg::FLG_OPERR]  <= op_fault_q;
      flags_q[sysflag_pkg::FLG_ON]     <= 1'b1;
      flags_q[sysflag_pkg::FLG_OFF]    <= 1'b0;
      flags_q[sysflag_pkg::FLG_FSH]    <= first_scan_q;
      flags_q[sysflag_pkg::FLG_FSL]    <= ~first_scan_q;
      flags_q[sysflag_pkg::FLG_PARITY] <= scan_parity_q;
      flags_q[sysflag_pkg::FLG_INITD]  <= init_flag_q;
      square_wave_q                    <= waves;
    end
  end

  // APB read mux, captured at setup so data stand through the access phase
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      sysflag_pkg::OFS_FLAGS:    rd_d = {24'h00_0000, flags_q};
      sysflag_pkg::OFS_CTRL:     rd_d = {31'h0000_0000, legacy_q};
      sysflag_pkg::OFS_DATE:     rd_d = date_q;
      sysflag_pkg::OFS_TOD:      rd_d = tod_q;
      sysflag_pkg::OFS_WEEK:     rd_d = {29'h0000_0000, week_out};
      sysflag_pkg::OFS_IRQ_STAT: rd_d = {30'h0000_0000, irq_stat_q};
      sysflag_pkg::OFS_IRQ_MASK: rd_d = {30'h0000_0000, irq_mask_q};
      sysflag_pkg::OFS_SQW:      rd_d = {24'h00_0000, square_wave_q};
      default:                   rd_d = 32'h0000_0000;
    endcase
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= sysflag_pkg::OFS_SQW) && (a[1:0] == 2'h0);
  endfunction : mapped

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (rd_en) begin
        prdata <= rd_d;
      end
      // Zero-wait answer: ready in every access cycle
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
    end
  end

  // Unused set_clk kept for future calendar strobe
  logic unused_ok;
  assign unused_ok = set_clk;

  a_latch_holds : assert property (@(posedge pclk) disable iff (!presetn)
    (run_event.op_done && run_event.op_fault) |=> block_fault_latch_q) else $error("fault latch not set");
  a_latch_clear_sw : assert property (@(posedge pclk) disable iff (!presetn)
    (latch_clr && !run_event.op_done) |=> !block_fault_latch_q) else $error("latch clear lost");
  a_operr_follows : assert property (@(posedge pclk) disable iff (!presetn)
    run_event.op_done |=> op_fault_q == $past(run_event.op_fault)) else $error("op fault stale");
  a_const_flags : assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (flags_q[sysflag_pkg::FLG_OFF] == 1'b0)) else $error("constant low set");
  a_first_scan_pair : assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[sysflag_pkg::FLG_FSH] |-> !flags_q[sysflag_pkg::FLG_FSL]) else $error("first scan flags agree");
  a_parity_first : assert property (@(posedge pclk) disable iff (!presetn)
    (run_event.scan_start && phase_q == sysflag_pkg::PH_WAIT && !run_event.program_start)
    |=> scan_parity_q && first_scan_q) else $error("first scan parity wrong");
  a_scan_after_init : assert property (@(posedge pclk) disable iff (!presetn)
    (phase_q == sysflag_pkg::PH_INIT) |=> !scan_enable_q) else $error("scan enabled during init");
  a_week_range : assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (week_q < 3'h7)) else $error("weekday out of range");
  a_on_always : assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> flags_q[sysflag_pkg::FLG_ON]) else $error("constant high clear");

endmodule : sysflag_gen

// ---- logic/sysflag_pkg.sv ----
// Package: register map, fields and timing constants of the system flag block
package sysflag_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // Periods of the square waves, in milliseconds
  localparam int unsigned SQW_COUNT = 8;
  localparam int unsigned SQW_PERIOD_MS [SQW_COUNT] = '{20, 100, 200, 1000, 2000, 10000, 20000, 60000};
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;

  // Time of day wraps after one day
  localparam int unsigned MS_PER_DAY = 86_400_000;
  localparam int unsigned DAYS_PER_WEEK = 7;
  // 1 January 1984, day zero, fell on a Sunday
  localparam logic [2:0] DAY0_WEEKDAY = 3'h0;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_DATE     = 8'h08;
  localparam logic [7:0] OFS_TOD      = 8'h0C;
  localparam logic [7:0] OFS_WEEK     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_SQW      = 8'h1C;

  // Flags register bit positions
  localparam int unsigned FLG_LATCH  = 0;
  localparam int unsigned FLG_OPERR  = 1;
  localparam int unsigned FLG_ON     = 2;
  localparam int unsigned FLG_OFF    = 3;
  localparam int unsigned FLG_FSH    = 4;
  localparam int unsigned FLG_FSL    = 5;
  localparam int unsigned FLG_PARITY = 6;
  localparam int unsigned FLG_INITD  = 7;

  // Control register bit positions
  localparam int unsigned CTL_LEGACY = 0;
  localparam int unsigned CTL_SETCLK = 1;

  // Interrupt status bit positions
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_SCAN  = 1;
  localparam int unsigned IRQ_WIDTH = 2;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_INIT = 4'h2,
    PH_WAIT = 4'h4,
    PH_SCAN = 4'h8
  } phase_e;

  typedef struct packed {
    logic scan_start;
    logic program_start;
    logic block_end;
    logic op_done;
    logic op_fault;
  } run_event_s;

endpackage : sysflag_pkg

// ---- verification/scan_program_model.sv ----
// User program model: run events and startup handshake seen by the flag block
`timescale 1ns/100ps
module scan_program_model (
  input  wire logic               pclk,
  input  wire logic               scan_enable_q,
  output sysflag_pkg::run_event_s run_event,
  output logic                    init_done
);
  initial begin
    run_event = '0;
    init_done = 1'b0;
  end

  // One-cycle pulse, changed just after the edge
  task automatic pulse(input logic [4:0] v);
    @(posedge pclk);
    run_event <= sysflag_pkg::run_event_s'(v);
    @(posedge pclk);
    run_event <= '0;
  endtask : pulse

  // Init block raises startup-complete before it ends
  task automatic run_init();
    pulse(5'h08);
    @(posedge pclk);
    init_done <= 1'b1;
    pulse(5'h04);
  endtask : run_init

  // Scans are far shorter than the fastest wave half period
  task automatic scan();
    int n;
    n = 0;
    while (scan_enable_q !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    pulse(5'h10);
  endtask : scan

  task automatic op(input logic fault);
    pulse({3'h0, 1'b1, fault});
  endtask : op
endmodule : scan_program_model

// ---- verification/sysflag_gen_bench.sv ----
// Testbench for the system flag generator
`timescale 1ns/100ps
module sysflag_gen_bench;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  sysflag_pkg::run_event_s run_event;
  logic                    init_done;
  logic                    scan_enable_q;
  logic [7:0]              flags_q;
  logic [7:0]              square_wave_q;
  logic                    irq_q;
  int                      mismatches;
  int                      checked;
  logic [31:0]             rd;
  logic                    err;

  sysflag_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_event(run_event), .init_done(init_done), .scan_enable_q(scan_enable_q), .flags_q(flags_q),
    .square_wave_q(square_wave_q), .irq_q(irq_q));

  scan_program_model model (.pclk(pclk), .scan_enable_q(scan_enable_q), .run_event(run_event),
    .init_done(init_done));

  always #25 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Request held until pready is sampled high at a rising edge; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask : settle

  task automatic t_startup();
    check({30'h0, flags_q[3:2]}, 32'h1);
    model.pulse(5'h08);
    settle();
    check(scan_enable_q, 1'b0);
    model.run_init();
    settle();
    check({31'h0, scan_enable_q}, 32'h1);
    check({31'h0, flags_q[7]}, 32'h1);
  endtask : t_startup

  // Three scans: first-scan flags, parity and waves restarting low
  task automatic t_scans();
    model.scan();
    settle();
    check({27'h0, flags_q[6:2]}, 32'h15);
    check({24'h0, square_wave_q}, 32'h0);
    model.scan();
    settle();
    check({27'h0, flags_q[6:2]}, 32'h09);
    model.scan();
    settle();
    check({27'h0, flags_q[6:2]}, 32'h19);
    apb(1'b0, sysflag_pkg::OFS_SQW, 32'h0);
    check(rd, 32'h0);
  endtask : t_scans

  task automatic t_fault();
    model.op(1'b1);
    settle();
    check({30'h0, flags_q[1:0]}, 32'h3);
    model.op(1'b0);
    settle();
    check({30'h0, flags_q[1:0]}, 32'h1);
    apb(1'b1, sysflag_pkg::OFS_FLAGS, 32'h1);
    settle();
    check({30'h0, flags_q[1:0]}, 32'h0);
    model.op(1'b1);
    model.pulse(5'h04);
    settle();
    check({30'h0, flags_q[1:0]}, 32'h2);
  endtask : t_fault

  // Mask polarity left to the design: the two settings must disagree
  task automatic t_irq();
    logic open_irq;
    apb(1'b1, sysflag_pkg::OFS_IRQ_MASK, 32'h0);
    settle();
    open_irq = irq_q;
    apb(1'b1, sysflag_pkg::OFS_IRQ_MASK, 32'h3);
    settle();
    check({31'h0, open_irq ^ irq_q}, 32'h1);
    apb(1'b1, sysflag_pkg::OFS_IRQ_STAT, 32'h3);
    apb(1'b0, sysflag_pkg::OFS_IRQ_STAT, 32'h0);
    check(rd, 32'h0);
    check({31'h0, irq_q}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask : t_irq

  task automatic t_calendar();
    for (int d = 1000; d < 1007; d++) begin
      apb(1'b1, sysflag_pkg::OFS_CTRL, 32'h0);
      apb(1'b1, sysflag_pkg::OFS_DATE, d);
      apb(1'b0, sysflag_pkg::OFS_WEEK, 32'h0);
      check(rd, d % 7);
      apb(1'b1, sysflag_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, sysflag_pkg::OFS_WEEK, 32'h0);
      check(rd, (d + 6) % 7);
    end
    apb(1'b1, sysflag_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, sysflag_pkg::OFS_TOD, sysflag_pkg::MS_PER_DAY - 1);
    repeat (sysflag_pkg::MS_CYCLES + 10) @(posedge pclk);
    apb(1'b0, sysflag_pkg::OFS_TOD, 32'h0);
    check({31'h0, rd < 2}, 32'h1);
    apb(1'b0, sysflag_pkg::OFS_DATE, 32'h0);
    check(rd, 32'd1007);
  endtask : t_calendar

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Whole run is about 20k cycles
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    t_startup();
    t_scans();
    t_fault();
    t_irq();
    t_calendar();
    report_and_stop();
  end
endmodule : sysflag_gen_bench
